/* hw/eix_index_qual.sv */
// Input synchroniser and index event qualifier
`timescale 1ns/1ps
module eix_index_qual (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             enc_a,
  input  wire logic             enc_b,
  input  wire logic             enc_n,
  input  wire logic             pol_n,
  input  wire eix_pkg::eix_sens_t sens,
  input  wire logic             pol_a,
  input  wire logic             pol_b,
  input  wire logic             ign_ab,
  output logic                  a_sync,
  output logic                  b_sync,
  output logic                  n_sync,
  output logic                  idx_evt
);
  import eix_pkg::*;

  logic [2:0] meta_q;     // First stage, read only by second
  logic [2:0] sync_q;     // Second stage: {n, b, a}
  logic       n_prev_q;   // Index one cycle earlier
  logic       act_now;    // Index at active level
  logic       act_prev;   // Index was at active level
  logic       ab_ok;      // A and B levels allow the event

  // ==========================================================================
  // Two-flop synchronisers for pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= 3'h0;
      sync_q   <= 3'h0;
      n_prev_q <= 1'b0;
    end else begin
      meta_q   <= {enc_n, enc_b, enc_a};
      sync_q   <= meta_q;
      n_prev_q <= sync_q[2];
    end
  end

  assign a_sync = sync_q[0];
  assign b_sync = sync_q[1];
  assign n_sync = sync_q[2];

  // ==========================================================================
  // Qualification
  // Polarity folded in first so every mode sees a plain active flag
  assign act_now  = (sync_q[2] == pol_n);
  assign act_prev = (n_prev_q == pol_n);
  // A/B gate; bypassed entirely when ignore bit is set
  assign ab_ok    = ign_ab | ((sync_q[0] == pol_a) & (sync_q[1] == pol_b));

  // Edge modes compare successive samples, so each event lasts one cycle
  always_comb begin
    case (sens)
      SENS_LEVEL: idx_evt = act_now & ab_ok;
      SENS_ACT:   idx_evt = act_now & ~act_prev & ab_ok;
      SENS_INACT: idx_evt = ~act_now & act_prev & ab_ok;
      default:    idx_evt = (act_now ^ act_prev) & ab_ok;
    endcase
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sync_two_stage: assert property (##2 n_sync == $past(enc_n, 2))
    else $error("index sync is not two stages");
  a_level_follow: assert property ((sens == SENS_LEVEL) && ab_ok |-> idx_evt == (n_sync == pol_n))
    else $error("level event does not follow index");
  a_rise_only: assert property (idx_evt && sens == SENS_ACT |-> n_sync == pol_n && $past(n_sync) != pol_n)
    else $error("active-edge event without active edge");
  a_fall_only: assert property (idx_evt && sens == SENS_INACT |-> n_sync != pol_n && $past(n_sync) == pol_n)
    else $error("inactive-edge event without inactive edge");
  a_both_edges: assert property (idx_evt && sens == SENS_BOTH |-> n_sync != $past(n_sync))
    else $error("both-edge event without edge");
  a_ab_levels: assert property (idx_evt && !ign_ab |-> a_sync == pol_a && b_sync == pol_b)
    else $error("event with wrong A or B level");
  a_edge_pulse: assert property (idx_evt && sens != SENS_LEVEL && $stable(sens) ##1 $stable(sens) |-> !idx_evt)
    else $error("edge event longer than one cycle");

endmodule

/* hw/eix_pkg.sv */
// Constants, field layout and register map of the encoder index event block
package eix_pkg;

  // ==========================================================================
  // Bus shape
  localparam int unsigned APB_AW = 8;         // Byte address width
  localparam int unsigned APB_DW = 32;        // Data width

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [APB_AW-1:0] IDX_CFG    = 8'h07;  // encoder_input_config
  localparam logic [APB_AW-1:0] IDX_POS    = 8'h10;  // Position counter
  localparam logic [APB_AW-1:0] IDX_CAP    = 8'h11;  // Captured position
  localparam logic [APB_AW-1:0] IDX_RELOAD = 8'h12;  // Reload value
  localparam logic [APB_AW-1:0] IDX_CONST  = 8'h13;  // Encoder constant
  localparam logic [APB_AW-1:0] IDX_STAT   = 8'h14;  // Live levels and flags

  // ==========================================================================
  // Config field positions
  localparam int unsigned CFG_DECIMAL = 0;    // Constant fraction is decimal
  localparam int unsigned CFG_CLR_ON  = 1;    // Reload on index event
  localparam int unsigned CFG_CONT    = 2;    // Act on every event
  localparam int unsigned CFG_ONCE    = 3;    // Act on next event only
  localparam int unsigned CFG_POL_N   = 4;    // Index active level
  localparam int unsigned CFG_SENS_LO = 5;    // Sensitivity field, 2 bits
  localparam int unsigned CFG_POL_A   = 7;    // Required A level
  localparam int unsigned CFG_POL_B   = 8;    // Required B level
  localparam int unsigned CFG_IGN_AB  = 9;    // Ignore A and B levels
  localparam int unsigned CFG_LATCH   = 10;   // Capture position
  localparam int unsigned CFG_W       = 11;   // Implemented config bits

  // ==========================================================================
  // Reset values
  localparam logic [APB_DW-1:0] CFG_RST    = 32'h00000400;
  localparam logic [APB_DW-1:0] CONST_RST  = 32'h00010000;  // 1.0 per step
  localparam logic [APB_DW-1:0] WORD_ZERO  = 32'h00000000;

  // ==========================================================================
  // Status bit positions
  localparam int unsigned ST_A      = 0;      // Synchronised A
  localparam int unsigned ST_B      = 1;      // Synchronised B
  localparam int unsigned ST_N      = 2;      // Synchronised index
  localparam int unsigned ST_CAPPED = 3;      // Capture happened, write 1 clears

  // ==========================================================================
  // Fraction moduli of the encoder constant
  localparam logic [16:0] FRAC_MOD_BIN = 17'h10000;  // Binary: 65536
  localparam logic [16:0] FRAC_MOD_DEC = 17'h02710;  // Decimal: 10000

  // ==========================================================================
  // Index sensitivity modes
  typedef enum logic [1:0] {
    SENS_LEVEL  = 2'b00,
    SENS_ACT    = 2'b01,
    SENS_INACT  = 2'b10,
    SENS_BOTH   = 2'b11
  } eix_sens_t;

endpackage

/* hw/eix_top.sv */
// Encoder index event block: APB registers, position counter, reload and capture
`timescale 1ns/1ps
module eix_top (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [eix_pkg::APB_AW-1:0]  paddr,
  input  wire logic [eix_pkg::APB_DW-1:0]  pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [eix_pkg::APB_DW-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        enc_a,
  input  wire logic                        enc_b,
  input  wire logic                        enc_n,
  output logic                             index_event,
  output logic      [eix_pkg::APB_DW-1:0]  enc_pos
);
  import eix_pkg::*;

  // ==========================================================================
  // Declarations
  logic [CFG_W-1:0]   cfg_q;        // Index configuration
  logic [APB_DW-1:0]  pos_q;        // Position integer part
  logic [15:0]        frac_q;       // Position fraction part
  logic [APB_DW-1:0]  cap_q;        // Captured position
  logic [APB_DW-1:0]  reload_q;     // Value loaded on index event
  logic [APB_DW-1:0]  const_q;      // Encoder constant, int.frac
  logic               capped_q;     // Sticky capture flag
  logic [APB_DW-1:0]  prdata_q;     // Read data, loaded in setup
  logic               perr_q;       // Unmapped address seen in setup
  logic               a_s;          // Synchronised A
  logic               b_s;          // Synchronised B
  logic               n_s;          // Synchronised index
  logic               a_prev_q;     // A one cycle earlier
  logic               b_prev_q;     // B one cycle earlier
  logic               idx_evt;      // Qualified index event
  logic               setup;        // APB setup phase
  logic               access;       // APB access phase
  logic [APB_DW-1:0]  wmerged;      // Write data merged with target
  logic               wr_cfg;       // Write strobes per register
  logic               wr_pos;
  logic               wr_reload;
  logic               wr_const;
  logic               wr_stat;
  logic               act;          // Event that clears or captures
  logic               do_reload;    // Reload position now
  logic               do_capture;   // Capture position now
  logic               once_done;    // One-shot request used up
  logic [1:0]         step;         // {step, up} from quadrature
  logic [16:0]        fmod;         // Fraction modulus in force
  logic [16:0]        fsum;         // Fraction sum, forward
  logic               carry;        // Fraction overflow, forward
  logic               borrow;       // Fraction underflow, backward
  logic [15:0]        frac_up;      // Next fraction, forward
  logic [15:0]        frac_dn;      // Next fraction, backward
  logic [APB_DW-1:0]  pos_up;       // Next position, forward
  logic [APB_DW-1:0]  pos_dn;       // Next position, backward

  // ==========================================================================
  // Functions
  // Register index to byte address
  function automatic logic [APB_AW-1:0] byte_addr(input logic [APB_AW-1:0] idx);
    byte_addr = APB_AW'({idx, 2'b00});
  endfunction

  // Decode: is this a mapped register
  function automatic logic addr_hit(input logic [APB_AW-1:0] a);
    if (a == byte_addr(IDX_CFG)) begin
      addr_hit = 1'b1;
    end else if (a == byte_addr(IDX_POS)) begin
      addr_hit = 1'b1;
    end else if (a == byte_addr(IDX_CAP)) begin
      addr_hit = 1'b1;
    end else if (a == byte_addr(IDX_RELOAD)) begin
      addr_hit = 1'b1;
    end else if (a == byte_addr(IDX_CONST)) begin
      addr_hit = 1'b1;
    end else if (a == byte_addr(IDX_STAT)) begin
      addr_hit = 1'b1;
    end else begin
      addr_hit = 1'b0;
    end
  endfunction

  // Byte-lane merge of write data into an old word
  function automatic logic [APB_DW-1:0] lane_merge(input logic [APB_DW-1:0] old_w,
                                                   input logic [APB_DW-1:0] new_w,
                                                   input logic [3:0]        strb);
    lane_merge = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        lane_merge[8*i +: 8] = new_w[8*i +: 8];
      end
    end
  endfunction

  // Quadrature decode: returns {step, up}; illegal double jumps are dropped
  function automatic logic [1:0] quad(input logic pa, input logic pb, input logic ca, input logic cb);
    case ({pa, pb, ca, cb})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: quad = 2'b11;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: quad = 2'b10;
      default:                            quad = 2'b00;
    endcase
  endfunction

  // ==========================================================================
  // Synchroniser and index qualifier
  eix_index_qual u_qual (
    .pclk    (pclk),
    .presetn (presetn),
    .enc_a   (enc_a),
    .enc_b   (enc_b),
    .enc_n   (enc_n),
    .pol_n   (cfg_q[CFG_POL_N]),
    .sens    (eix_sens_t'(cfg_q[CFG_SENS_LO +: 2])),
    .pol_a   (cfg_q[CFG_POL_A]),
    .pol_b   (cfg_q[CFG_POL_B]),
    .ign_ab  (cfg_q[CFG_IGN_AB]),
    .a_sync  (a_s),
    .b_sync  (b_s),
    .n_sync  (n_s),
    .idx_evt (idx_evt)
  );

  assign index_event = idx_evt;
  assign enc_pos     = pos_q;

  // ==========================================================================
  // APB slave
  // Zero wait states; read data is captured in setup so it comes from flops
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign pready  = 1'b1;
  assign pslverr = access & perr_q;
  assign prdata  = prdata_q;

  // Write strobes, only in the completing access cycle
  assign wr_cfg    = access & pwrite & (paddr == byte_addr(IDX_CFG));
  assign wr_pos    = access & pwrite & (paddr == byte_addr(IDX_POS));
  assign wr_reload = access & pwrite & (paddr == byte_addr(IDX_RELOAD));
  assign wr_const  = access & pwrite & (paddr == byte_addr(IDX_CONST));
  assign wr_stat   = access & pwrite & (paddr == byte_addr(IDX_STAT));

  // Merge source picked by address so partial writes keep other lanes
  always_comb begin
    if (paddr == byte_addr(IDX_CFG)) begin
      wmerged = lane_merge(APB_DW'(cfg_q), pwdata, pstrb);
    end else if (paddr == byte_addr(IDX_POS)) begin
      wmerged = lane_merge(pos_q, pwdata, pstrb);
    end else if (paddr == byte_addr(IDX_RELOAD)) begin
      wmerged = lane_merge(reload_q, pwdata, pstrb);
    end else if (paddr == byte_addr(IDX_CONST)) begin
      wmerged = lane_merge(const_q, pwdata, pstrb);
    end else begin
      wmerged = lane_merge(WORD_ZERO, pwdata, pstrb);
    end
  end

  // Read mux and error flag, loaded at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= WORD_ZERO;
      perr_q   <= 1'b0;
    end else if (setup) begin
      perr_q <= ~addr_hit(paddr);
      if (pwrite) begin
        prdata_q <= WORD_ZERO;
      end else if (paddr == byte_addr(IDX_CFG)) begin
        prdata_q <= APB_DW'(cfg_q);      // Upper bits read zero
      end else if (paddr == byte_addr(IDX_POS)) begin
        prdata_q <= pos_q;
      end else if (paddr == byte_addr(IDX_CAP)) begin
        prdata_q <= cap_q;
      end else if (paddr == byte_addr(IDX_RELOAD)) begin
        prdata_q <= reload_q;
      end else if (paddr == byte_addr(IDX_CONST)) begin
        prdata_q <= const_q;
      end else if (paddr == byte_addr(IDX_STAT)) begin
        prdata_q <= {28'h0000000, capped_q, n_s, b_s, a_s};
      end else begin
        prdata_q <= WORD_ZERO;           // Unmapped reads zero
      end
    end
  end

  // ==========================================================================
  // Index action decode
  // Clear and capture fire only when an every-event or next-event mode is armed
  assign act        = idx_evt & (cfg_q[CFG_CONT] | cfg_q[CFG_ONCE]);
  assign do_reload  = act & cfg_q[CFG_CLR_ON];
  assign do_capture = act & cfg_q[CFG_LATCH];
  assign once_done  = idx_evt & cfg_q[CFG_ONCE];

  // ==========================================================================
  // Configuration register
  // A software write in the same cycle wins over the one-shot self-clear,
  // so a re-arm is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RST[CFG_W-1:0];
    end else if (wr_cfg) begin
      cfg_q <= wmerged[CFG_W-1:0];
    end else if (once_done) begin
      cfg_q[CFG_ONCE] <= 1'b0;
    end
  end

  // Reload value and encoder constant
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_q <= WORD_ZERO;
      const_q  <= CONST_RST;
    end else begin
      if (wr_reload) begin
        reload_q <= wmerged;
      end
      if (wr_const) begin
        const_q <= wmerged;
      end
    end
  end

  // ==========================================================================
  // Quadrature step and constant arithmetic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
    end else begin
      a_prev_q <= a_s;
      b_prev_q <= b_s;
    end
  end

  assign step = quad(a_prev_q, b_prev_q, a_s, b_s);

  // Decimal mode wraps the fraction at 10000; software must keep it below that
  assign fmod    = cfg_q[CFG_DECIMAL] ? FRAC_MOD_DEC : FRAC_MOD_BIN;
  assign fsum    = {1'b0, frac_q} + {1'b0, const_q[15:0]};
  assign carry   = (fsum >= fmod);
  assign borrow  = (frac_q < const_q[15:0]);
  assign frac_up = carry ? 16'(fsum - fmod) : fsum[15:0];
  assign frac_dn = borrow ? 16'(({1'b0, frac_q} + fmod) - {1'b0, const_q[15:0]})
                          : 16'(frac_q - const_q[15:0]);
  assign pos_up  = pos_q + {16'h0000, const_q[31:16]} + {31'h00000000, carry};
  assign pos_dn  = pos_q - {16'h0000, const_q[31:16]} - {31'h00000000, borrow};

  // ==========================================================================
  // Position counter
  // Index reload beats a software write, which beats counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q  <= WORD_ZERO;
      frac_q <= 16'h0000;
    end else if (do_reload) begin
      pos_q  <= reload_q;
      frac_q <= 16'h0000;
    end else if (wr_pos) begin
      pos_q  <= wmerged;
      frac_q <= 16'h0000;
    end else if (step[1] && step[0]) begin
      pos_q  <= pos_up;
      frac_q <= frac_up;
    end else if (step[1]) begin
      pos_q  <= pos_dn;
      frac_q <= frac_dn;
    end
  end

  // ==========================================================================
  // Capture register and sticky flag
  // Capture takes the position before any same-cycle reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_q <= WORD_ZERO;
    end else if (do_capture) begin
      cap_q <= pos_q;
    end
  end

  // A new capture wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capped_q <= 1'b0;
    end else if (do_capture) begin
      capped_q <= 1'b1;
    end else if (wr_stat && wmerged[ST_CAPPED]) begin
      capped_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // One-shot capture followed by a later event with the mode not re-armed
  sequence s_once_fire;
    idx_evt && cfg_q[CFG_ONCE] && !cfg_q[CFG_CONT] && cfg_q[CFG_LATCH] && !wr_cfg;
  endsequence

  sequence s_later_event;
    idx_evt && !cfg_q[CFG_CONT] && !cfg_q[CFG_ONCE];
  endsequence

  a_reload_on_index: assert property (do_reload |=> pos_q == $past(reload_q) && frac_q == 16'h0000)
    else $error("position not reloaded on index event");
  a_no_reload_off: assert property (idx_evt && !cfg_q[CFG_CLR_ON] && !wr_pos && step == 2'b00
                                    |=> pos_q == $past(pos_q))
    else $error("position changed with reload disabled");
  a_capture_every: assert property (idx_evt && cfg_q[CFG_CONT] && cfg_q[CFG_LATCH]
                                    |=> cap_q == $past(pos_q) && capped_q)
    else $error("position not captured on index event");
  a_idle_no_capture: assert property (idx_evt && !cfg_q[CFG_CONT] && !cfg_q[CFG_ONCE]
                                      |=> $stable(cap_q) && $stable(pos_q) || $past(wr_pos || step != 2'b00))
    else $error("action taken with no mode armed");
  a_once_clears: assert property (idx_evt && cfg_q[CFG_ONCE] && !wr_cfg |=> !cfg_q[CFG_ONCE])
    else $error("one-shot bit not cleared after use");
  a_once_single: assert property (s_once_fire ##[1:64] s_later_event |=> $stable(cap_q))
    else $error("one-shot capture acted twice");
  a_no_latch_off: assert property (!cfg_q[CFG_LATCH] |=> $stable(cap_q))
    else $error("capture with capture disabled");
  a_dec_frac_bound: assert property (cfg_q[CFG_DECIMAL] && frac_q < 16'h2710 && const_q[15:0] < 16'h2710
                                     && !wr_cfg |=> frac_q < 16'h2710)
    else $error("decimal fraction left its range");
  a_bin_carry: assert property (!cfg_q[CFG_DECIMAL] && step == 2'b11 && !do_reload && !wr_pos
                                |=> {pos_q, frac_q} == $past({pos_q, frac_q}) + $past(const_q))
    else $error("binary constant not added as int.frac");
  a_apb_error: assert property (access && !addr_hit(paddr) |-> pslverr)
    else $error("unmapped access without error");

endmodule

/* tb/eix_enc_model.sv */
// Incremental encoder model driving the A, B and index pins
`timescale 1ns/1ps
module eix_enc_model (
  input  wire logic       pclk,
  input  wire logic [1:0] ab_req,
  input  wire logic       n_req,
  output logic            enc_a,
  output logic            enc_b,
  output logic            enc_n
);
  // ==========================================================================
  // Pin drivers
  // Pins start low so the block never sees an unknown level
  initial {enc_a, enc_b, enc_n} = 3'b000;
  // Pins move just after the same pclk rising edge on which the block samples them
  always @(posedge pclk) begin
    {enc_a, enc_b} <= ab_req;
    enc_n          <= n_req;
  end
endmodule

/* tb/tb.sv */
// Testbench of the encoder index event block
`timescale 1ns/1ps
module tb;
  import eix_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, enc_pos, rd;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, enc_a, enc_b, enc_n, index_event, err, n_req = 1'b0;
  logic [1:0]  ab_req = 2'b00;
  int          mismatches = 0, n_checks = 0, ev_cnt = 0, r, f;
  // A and B qualification table: config, pin levels {A,B}, events expected
  logic [31:0] ab_cfg [4] = '{32'h000000B0, 32'h000000B0, 32'h000000B0, 32'h000002B0};
  logic [1:0]  ab_lvl [4] = '{2'b00, 2'b10, 2'b11, 2'b11};
  int          ab_exp [4] = '{0, 1, 0, 1};

  // ==========================================================================
  // Clock, design, encoder
  always #4 pclk = ~pclk;
  eix_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
                 .prdata, .pready, .pslverr, .enc_a, .enc_b, .enc_n, .index_event, .enc_pos);
  eix_enc_model i_enc (.pclk, .ab_req, .n_req, .enc_a, .enc_b, .enc_n);
  // Counted on the falling edge, so counts never race the test sequence
  always @(negedge pclk) if (index_event === 1'b1) ev_cnt++;

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer by register index; an idle cycle follows
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx[5:0], 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Index high then low, ten cycles each; events counted per half
  task automatic pulse();
    int b;
    b = ev_cnt;
    n_req <= 1'b1;
    repeat (10) @(posedge pclk);
    r = ev_cnt - b;
    n_req <= 1'b0;
    repeat (10) @(posedge pclk);
    f = ev_cnt - b - r;
  endtask
  // Forward quadrature steps, each held long enough to cross the synchroniser
  task automatic fwd(input int n);
    for (int k = 0; k < n; k++) begin
      ab_req <= {ab_req[0], ~ab_req[1]};
      repeat (5) @(posedge pclk);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, IDX_CFG, 32'h00000000);
    chk(rd, CFG_RST);
    apb(1'b1, IDX_CFG, 32'hFFFFFFFF);
    apb(1'b0, IDX_CFG, 32'h00000000);
    chk(rd, 32'h000007FF);
    apb(1'b0, 8'h3F, 32'h00000000);
    chk({31'h0, err}, 32'h00000001);
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, IDX_CFG, 32'h00000210 | 32'(s << 5));
      pulse();
      if (s == 0) begin
        chk(32'(r + f), 32'h0000000A);
      end else begin
        chk(32'(r), 32'(s != 2));
        chk(32'(f), 32'(s >= 2));
      end
    end
    apb(1'b1, IDX_CFG, 32'h00000220);
    pulse();
    chk(32'(r + 2 * f), 32'h00000002);
    $display("test sensitivity done");
    for (int i = 0; i < 4; i++) begin
      ab_req <= ab_lvl[i];
      apb(1'b1, IDX_CFG, ab_cfg[i]);
      pulse();
      chk(32'(r), 32'(ab_exp[i]));
    end
    $display("test qualification done");
    apb(1'b1, IDX_RELOAD, 32'h00001234);
    apb(1'b1, IDX_CFG, 32'h0000063A);
    apb(1'b1, IDX_POS, 32'h00000055);
    pulse();
    chk(enc_pos, 32'h00001234);
    apb(1'b0, IDX_CAP, 32'h00000000);
    chk(rd, 32'h00000055);
    apb(1'b0, IDX_CFG, 32'h00000000);
    chk(rd, 32'h00000632);
    apb(1'b1, IDX_POS, 32'h00000077);
    pulse();
    chk(enc_pos, 32'h00000077);
    apb(1'b1, IDX_CFG, 32'h00000636);
    pulse();
    apb(1'b1, IDX_POS, 32'h00000099);
    pulse();
    chk(enc_pos, 32'h00001234);
    apb(1'b1, IDX_CFG, 32'h00000634);
    apb(1'b1, IDX_POS, 32'h00000077);
    pulse();
    chk(enc_pos, 32'h00000077);
    apb(1'b0, IDX_CAP, 32'h00000000);
    chk(rd, 32'h00000077);
    apb(1'b0, IDX_STAT, 32'h00000000);
    chk(rd, 32'h0000000B);
    apb(1'b1, IDX_STAT, 32'h00000008);
    apb(1'b0, IDX_STAT, 32'h00000000);
    chk(rd, 32'h00000003);
    $display("test reload and capture done");
    // Constant 1 plus fraction 5000: three forward steps give 4 in decimal, 3 in binary
    apb(1'b1, IDX_CONST, 32'h00011388);
    apb(1'b1, IDX_CFG, 32'h00000201);
    apb(1'b1, IDX_POS, 32'h00000000);
    fwd(3);
    chk(enc_pos, 32'h00000004);
    apb(1'b1, IDX_CFG, 32'h00000200);
    apb(1'b1, IDX_POS, 32'h00000000);
    fwd(3);
    chk(enc_pos, 32'h00000003);
    $display("test constant done");
    conclude();
  end
  // Watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    conclude();
  end
endmodule
